// file: clt_pkg.sv
package clt_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int DEADLOCK_MS = 10;
   localparam int PATH_BASE_US = 100;
   localparam int PATH_BYTE_US = 15;
   localparam int SHDLC_LIMIT_US = 500;
   localparam int GUARD_US = 180;
   localparam int DEADLOCK_CYC_DEF = DEADLOCK_MS * 1000 * CLK_MHZ;
   localparam int PATH_BASE_CYC_DEF = PATH_BASE_US * CLK_MHZ;
   localparam int PATH_BYTE_CYC_DEF = PATH_BYTE_US * CLK_MHZ;
   localparam int SHDLC_CYC_DEF = SHDLC_LIMIT_US * CLK_MHZ;
   localparam int GUARD_CYC_DEF = GUARD_US * CLK_MHZ;
   localparam int CNT_W = 24;
   // ----------------------------------------
   // Link frame layout
   // ----------------------------------------
   localparam logic [3:0] CODE_DATA = 4'h0;
   localparam logic [3:0] CODE_NOTICE = 4'h1;
   localparam logic [3:0] CODE_INIT = 4'h2;
   localparam logic [3:0] CODE_HALT = 4'h3;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [11:0] TYPE_BIT = 12'h000;
   localparam logic [11:0] CODE_LAST_BIT = 12'h004;
   localparam logic [11:0] FRAME_OVERHEAD_BITS = 12'h015;
   // ----------------------------------------
   // RF states and control states
   // ----------------------------------------
   localparam logic [1:0] RF_IDLE = 2'h0;
   localparam logic [1:0] RF_HALT = 2'h1;
   localparam logic [1:0] RF_ACTIVE = 2'h2;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_OPEN = 3'h1,
      S_WAIT = 3'h3,
      S_RFTX = 3'h2,
      S_RECOV = 3'h6
   } clt_state_e;
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_EVENTS = 8'h08;
   localparam int CTRL_EN = 0;
   localparam int CTRL_PIPE = 1;
   localparam int CTRL_DEACT = 2;
   localparam int EV_TIMEOUT = 0;
   localparam int EV_BAD_FRAME = 1;
   localparam int EV_SHDLC_CLOSE = 2;
   localparam int EV_OVERSIZE = 3;
   localparam int EV_RX_LATE = 4;
   localparam int EV_TX_LATE = 5;
   localparam int EV_GUARD_LATE = 6;
   localparam int EV_RESERVED = 7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: clt_session_ctrl.sv
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module clt_session_ctrl
   import clt_pkg::*;
#(
   parameter int DEADLOCK_CYC = DEADLOCK_CYC_DEF,
   parameter int PATH_BASE_CYC = PATH_BASE_CYC_DEF,
   parameter int PATH_BYTE_CYC = PATH_BYTE_CYC_DEF,
   parameter int SHDLC_CYC = SHDLC_CYC_DEF,
   parameter int GUARD_CYC = GUARD_CYC_DEF,
   parameter int MAX_PAYLOAD = 30
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic link_clk,
   input wire logic link_rx_frame,
   input wire logic link_rx_bit,
   input wire logic lk_shdlc_pending,
   input wire logic lk_tx_done,
   output logic lk_tx_req,
   output logic [3:0] lk_tx_code,
   output logic [7:0] lk_tx_len,
   output logic lk_tx_corrupt,
   output logic lk_higher_cmd,
   output logic lk_deactivate,
   input wire logic rf_field,
   input wire logic rf_selected,
   input wire logic rf_sel_from_halt,
   input wire logic rf_blk_end,
   input wire logic [7:0] rf_blk_len,
   input wire logic rf_req_cmd,
   input wire logic rf_mod_edge,
   output logic [1:0] rf_state,
   output logic rf_listen,
   output logic rf_tx_start,
   output logic [7:0] rf_tx_len,
   output logic rf_tx_abort
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      clt_state_e st;
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic [2:0] sy3;
      logic [11:0] bits;
      logic [15:0] crc;
      logic ftype;
      logic [3:0] code;
      logic pip_started;
      logic opened;
      logic from_halt;
      logic [1:0] rf_state;
      logic rf_listen;
      logic rf_tx_start;
      logic [7:0] rf_tx_len;
      logic rf_tx_abort;
      logic pend;
      logic [7:0] pend_len;
      logic pend_over;
      logic lk_tx_req;
      logic [3:0] lk_tx_code;
      logic [7:0] lk_tx_len;
      logic lk_tx_corrupt;
      logic lk_higher_cmd;
      logic lk_deactivate;
      logic [CNT_W-1:0] tmo;
      logic rx_run;
      logic [CNT_W-1:0] rx_cnt;
      logic [CNT_W-1:0] rx_lim;
      logic tx_run;
      logic tx_shdlc;
      logic [CNT_W-1:0] tx_cnt;
      logic gd_run;
      logic [CNT_W-1:0] gd_cnt;
      logic [2:0] ctrl;
      logic [7:0] events;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } clt_regs_s;

   clt_regs_s q;
   clt_regs_s next_q;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction

   function automatic logic [CNT_W-1:0] path_lim(input logic [7:0] nbytes);
      return CNT_W'(PATH_BASE_CYC) + CNT_W'(nbytes) * CNT_W'(PATH_BYTE_CYC);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return (&v) ? v : v + CNT_W'(1);
   endfunction

   logic clk_rise;
   logic frm_rise;
   logic fr_end;
   logic crc_ok;
   logic [7:0] pay_bytes;
   logic code_seen;
   logic tx_stop;

   assign clk_rise = q.sy2[2] & ~q.sy3[2];
   assign frm_rise = q.sy2[1] & ~q.sy3[1];
   assign fr_end = ~q.sy2[1] & q.sy3[1];
   assign crc_ok = (q.crc == 16'h0000) && (q.bits >= FRAME_OVERHEAD_BITS);
   assign pay_bytes = (q.bits >= FRAME_OVERHEAD_BITS) ?
                      8'((q.bits - FRAME_OVERHEAD_BITS) >> 3) : 8'h00;
   assign code_seen = clk_rise && q.sy2[1] && (q.bits == CODE_LAST_BIT);

   always_comb begin
      next_q = q;
      next_q.rf_tx_start = 1'b0;
      next_q.rf_tx_abort = 1'b0;
      next_q.lk_tx_req = 1'b0;
      next_q.lk_higher_cmd = 1'b0;
      tx_stop = 1'b0;
      // Clear first so that any event raised below in the same cycle survives
      if (q.aw_got && q.w_got && !q.bvalid && q.aw_addr == REG_EVENTS && q.w_strb[0]) begin
         next_q.events = q.events & ~q.w_data[7:0];
      end
      // ----------------------------------------
      // Link pin sampling and serial capture
      // ----------------------------------------
      next_q.sy1 = {link_clk, link_rx_frame, link_rx_bit};
      next_q.sy2 = q.sy1;
      next_q.sy3 = q.sy2;
      if (frm_rise) begin
         next_q.bits = 12'h000;
         next_q.crc = CRC_INIT;
         next_q.code = 4'h0;
         next_q.pip_started = 1'b0;
      end else if (clk_rise && q.sy2[1]) begin
         next_q.bits = q.bits + 12'h001;
         next_q.crc = crc_step(q.crc, q.sy2[0]);
         if (q.bits == TYPE_BIT) begin
            next_q.ftype = q.sy2[0];
         end else if (q.bits <= CODE_LAST_BIT) begin
            next_q.code = {q.code[2:0], q.sy2[0]};
         end
      end
      // ----------------------------------------
      // RF selection
      // ----------------------------------------
      if (rf_selected) begin
         next_q.rf_state = RF_ACTIVE;
         next_q.from_halt = rf_sel_from_halt;
      end
      if (rf_blk_end && q.rf_listen && q.ctrl[CTRL_EN] && q.rf_state == RF_ACTIVE &&
          q.st == S_IDLE) begin
         next_q.pend = 1'b1;
         next_q.pend_len = rf_blk_len;
         next_q.pend_over = (rf_blk_len > 8'(MAX_PAYLOAD));
      end
      // ----------------------------------------
      // Session sequencing
      // ----------------------------------------
      case (q.st)
         S_IDLE: begin
            if (q.pend && !lk_shdlc_pending && !q.sy2[1]) begin
               next_q.pend = 1'b0;
               next_q.lk_tx_req = 1'b1;
               next_q.lk_tx_code = q.opened ? CODE_DATA : CODE_NOTICE;
               next_q.lk_tx_len = q.pend_over ? 8'(MAX_PAYLOAD) : q.pend_len;
               next_q.lk_tx_corrupt = q.pend_over;
               next_q.events[EV_OVERSIZE] = next_q.events[EV_OVERSIZE] | q.pend_over;
               next_q.opened = 1'b1;
               next_q.st = S_OPEN;
            end
         end
         S_OPEN: begin
            if (lk_tx_done) begin
               next_q.tmo = '0;
               next_q.st = S_WAIT;
            end
         end
         S_WAIT: begin
            next_q.tmo = q.tmo + CNT_W'(1);
            if (code_seen && q.ftype && {q.code[2:0], q.sy2[0]} == CODE_DATA &&
                q.ctrl[CTRL_PIPE]) begin
               next_q.pip_started = 1'b1;
               next_q.rf_tx_start = 1'b1;
               next_q.rf_tx_len = 8'h00;
            end
            if (fr_end && q.ftype) begin
               if (!crc_ok) begin
                  next_q.events[EV_BAD_FRAME] = 1'b1;
                  next_q.rf_tx_abort = q.pip_started;
               end else begin
                  case (q.code)
                     CODE_INIT: begin
                        next_q.rf_state = q.from_halt ? RF_HALT : RF_IDLE;
                        next_q.opened = 1'b0;
                        next_q.st = S_IDLE;
                     end
                     CODE_HALT: begin
                        next_q.rf_state = RF_HALT;
                        next_q.opened = 1'b0;
                        next_q.st = S_IDLE;
                     end
                     CODE_DATA: begin
                        if (!q.pip_started && pay_bytes != 8'h00) begin
                           next_q.rf_tx_start = 1'b1;
                        end
                        next_q.rf_tx_len = pay_bytes;
                        next_q.st = S_RFTX;
                     end
                     default: begin
                        next_q.events[EV_RESERVED] = 1'b1;
                     end
                  endcase
               end
            end
            if (q.tmo >= CNT_W'(DEADLOCK_CYC - 1)) begin
               next_q.st = S_RECOV;
            end
         end
         S_RFTX: begin
            tx_stop = (q.rf_tx_len == 8'h00);
            next_q.st = S_IDLE;
         end
         S_RECOV: begin
            next_q.rf_state = RF_IDLE;
            next_q.opened = 1'b0;
            next_q.lk_higher_cmd = ~q.ctrl[CTRL_DEACT];
            next_q.lk_deactivate = q.ctrl[CTRL_DEACT];
            next_q.events[EV_TIMEOUT] = 1'b1;
            next_q.st = S_IDLE;
         end
         default: begin
            next_q.st = S_IDLE;
         end
      endcase
      if (fr_end && !q.ftype && q.bits != TYPE_BIT) begin
         next_q.events[EV_SHDLC_CLOSE] = next_q.events[EV_SHDLC_CLOSE] | q.opened;
         next_q.opened = 1'b0;
         if (q.st == S_OPEN || q.st == S_WAIT) begin
            next_q.st = S_IDLE;
         end
      end
      if (!rf_field) begin
         next_q.st = S_IDLE;
         next_q.opened = 1'b0;
         next_q.pend = 1'b0;
         next_q.rf_state = RF_IDLE;
         next_q.lk_deactivate = 1'b0;
      end
      next_q.rf_listen = rf_field && next_q.st != S_OPEN && next_q.st != S_WAIT;
      // ----------------------------------------
      // Latency monitors
      // ----------------------------------------
      tx_stop = tx_stop | rf_mod_edge;
      if (rf_blk_end) begin
         next_q.rx_run = 1'b1;
         next_q.rx_cnt = '0;
         next_q.rx_lim = q.ctrl[CTRL_EN] ? path_lim(rf_blk_len) + CNT_W'(1)
                                         : CNT_W'(SHDLC_CYC);
      end else if (q.rx_run) begin
         next_q.rx_cnt = sat_inc(q.rx_cnt);
         if (lk_tx_done) begin
            next_q.rx_run = 1'b0;
            next_q.events[EV_RX_LATE] = next_q.events[EV_RX_LATE] | (q.rx_cnt >= q.rx_lim);
         end
      end
      // timed from first SOF of a burst
      if (frm_rise && !q.tx_run) begin
         next_q.tx_run = 1'b1;
         next_q.tx_cnt = '0;
      end else if (q.tx_run) begin
         next_q.tx_cnt = sat_inc(q.tx_cnt);
         if (fr_end) begin
            next_q.tx_shdlc = ~q.ftype;
         end
         if (tx_stop) begin
            next_q.tx_run = 1'b0;
            next_q.events[EV_TX_LATE] = next_q.events[EV_TX_LATE] |
               (q.tx_shdlc ? q.tx_cnt >= CNT_W'(SHDLC_CYC)
                           : q.tx_cnt > path_lim(q.rf_tx_len));
         end
      end
      if (rf_blk_end && rf_req_cmd) begin
         next_q.gd_run = 1'b1;
         next_q.gd_cnt = '0;
      end else if (q.gd_run) begin
         next_q.gd_cnt = sat_inc(q.gd_cnt);
         if (tx_stop || (q.st == S_WAIT && next_q.st == S_IDLE)) begin
            next_q.gd_run = 1'b0;
            next_q.events[EV_GUARD_LATE] = next_q.events[EV_GUARD_LATE] |
                                           (q.gd_cnt > CNT_W'(GUARD_CYC));
         end
      end
      // ----------------------------------------
      // Register bus
      // ----------------------------------------
      if (awvalid && q.awready) begin
         next_q.aw_got = 1'b1;
         next_q.aw_addr = awaddr;
      end
      if (wvalid && q.wready) begin
         next_q.w_got = 1'b1;
         next_q.w_data = wdata;
         next_q.w_strb = wstrb;
      end
      if (q.bvalid && bready) begin
         next_q.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         next_q.aw_got = 1'b0;
         next_q.w_got = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp = RESP_OKAY;
         case (q.aw_addr)
            REG_CTRL: begin
               next_q.ctrl = 3'(merge({29'h0, q.ctrl}, q.w_data, q.w_strb));
            end
            REG_EVENTS: begin
               // Cleared at the top so that a set in the same cycle wins
            end
            REG_STATUS: begin
            end
            default: begin
               next_q.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (q.rvalid && rready) begin
         next_q.rvalid = 1'b0;
      end
      if (arvalid && q.arready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp = RESP_OKAY;
         case (araddr)
            REG_CTRL: next_q.rdata = {29'h0, q.ctrl};
            REG_STATUS: next_q.rdata = {24'h0, q.lk_deactivate, q.opened, q.rf_state,
                                        1'b0, q.st};
            REG_EVENTS: next_q.rdata = {24'h0, q.events};
            default: begin
               next_q.rdata = 32'h0;
               next_q.rresp = RESP_SLVERR;
            end
         endcase
      end
      next_q.awready = !next_q.aw_got && !next_q.bvalid;
      next_q.wready = !next_q.w_got && !next_q.bvalid;
      next_q.arready = !next_q.rvalid;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign awready = q.awready;
   assign wready = q.wready;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign arready = q.arready;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign lk_tx_req = q.lk_tx_req;
   assign lk_tx_code = q.lk_tx_code;
   assign lk_tx_len = q.lk_tx_len;
   assign lk_tx_corrupt = q.lk_tx_corrupt;
   assign lk_higher_cmd = q.lk_higher_cmd;
   assign lk_deactivate = q.lk_deactivate;
   assign rf_state = q.rf_state;
   assign rf_listen = q.rf_listen;
   assign rf_tx_start = q.rf_tx_start;
   assign rf_tx_len = q.rf_tx_len;
   assign rf_tx_abort = q.rf_tx_abort;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_no_tx_pending: assert property (@(posedge clock) disable iff (srst)
      q.lk_tx_req |-> !$past(lk_shdlc_pending)) else $error("frame issued while busy");
   a_open_notice: assert property (@(posedge clock) disable iff (srst)
      $rose(q.opened) |-> q.lk_tx_req && q.lk_tx_code == CODE_NOTICE)
      else $error("session opened without notice");
   a_init_branch: assert property (@(posedge clock) disable iff (srst)
      (q.st == S_WAIT && fr_end && q.ftype && crc_ok && q.code == CODE_INIT && rf_field &&
       q.tmo < CNT_W'(DEADLOCK_CYC - 1))
      |=> q.rf_state == ($past(q.from_halt) ? RF_HALT : RF_IDLE))
      else $error("wrong state after init code");
   a_halt_code: assert property (@(posedge clock) disable iff (srst)
      (q.st == S_WAIT && fr_end && q.ftype && crc_ok && q.code == CODE_HALT && rf_field)
      |=> q.rf_state == RF_HALT ##1 !q.opened) else $error("halt code not obeyed");
   a_shdlc_close: assert property (@(posedge clock) disable iff (srst)
      (fr_end && !q.ftype && q.bits != TYPE_BIT) |=> !q.opened)
      else $error("SHDLC frame left session open");
   a_deadlock_exit: assert property (@(posedge clock) disable iff (srst)
      (q.st == S_WAIT && q.tmo == CNT_W'(DEADLOCK_CYC - 1) && rf_field && !fr_end)
      |=> q.st == S_RECOV ##1 q.rf_state == RF_IDLE) else $error("no deadlock recovery");
   a_link_only: assert property (@(posedge clock) disable iff (srst)
      q.st == S_WAIT |-> !q.rf_listen) else $error("RF heard while waiting");
   a_bad_nomod: assert property (@(posedge clock) disable iff (srst)
      (q.st == S_WAIT && fr_end && q.ftype && !crc_ok && !q.pip_started)
      |=> !q.rf_tx_start && q.st != S_RFTX) else $error("modulated on bad check");
endmodule
`default_nettype wire

// file: clt_card_model.sv
`timescale 1ns/100ps
`default_nettype none
module clt_card_model
   import clt_pkg::*;
(
   input wire logic clock,
   input wire logic lk_tx_req,
   output logic lk_tx_done,
   output logic link_clk,
   output logic link_rx_frame,
   output logic link_rx_bit
);
   logic [20:0] done_sr = '0;
   initial begin
      link_clk = 1'h0;
      link_rx_frame = 1'h0;
      link_rx_bit = 1'h0;
   end
   // Outgoing frame takes a while on the wire before its end is reported
   always @(posedge clock) begin
      done_sr <= {done_sr[19:0], lk_tx_req};
   end
   assign lk_tx_done = done_sr[20];
   // one whole frame per answer, only when told to
   task automatic send_frame(input logic [3:0] code, input int nbytes, input logic bad);
      logic q[$];
      logic [15:0] crc;
      q.push_back(1'h1);
      for (int i = 3; i >= 0; i--) q.push_back(code[i]);
      for (int i = 0; i < nbytes * 8; i++) q.push_back(i[0] ^ i[2]);
      crc = CRC_INIT;
      foreach (q[i]) crc = {crc[14:0], 1'h0} ^ ((crc[15] ^ q[i]) ? CRC_POLY : 16'h0000);
      crc = crc ^ {16{bad}};
      for (int i = 15; i >= 0; i--) q.push_back(crc[i]);
      #1 link_rx_frame = 1'h1;
      foreach (q[i]) begin
         link_rx_bit = q[i];
         #62.5 link_clk = 1'h1;
         #62.5 link_clk = 1'h0;
      end
      link_rx_frame = 1'h0;
      // Released line must not look like a held bit
      link_rx_bit = ~link_rx_bit;
   endtask
endmodule
`default_nettype wire

// file: clt_session_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module clt_session_ctrl_tb_top
   import clt_pkg::*;
   ;
   localparam int DL = 4000;
   logic clock = 1'h0, srst = 1'h1;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rf_blk_len = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic rf_field = 1'h1, rf_selected = 1'h0, rf_sel_from_halt = 1'h0, rf_blk_end = 1'h0;
   logic [3:0] wstrb = 4'hf;
   logic lk_shdlc_pending = 1'h0, rf_req_cmd = 1'h0, rf_mod_edge = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, link_clk, link_rx_frame, link_rx_bit;
   logic lk_tx_done, lk_tx_req, lk_tx_corrupt, lk_higher_cmd, lk_deactivate;
   logic rf_listen, rf_tx_start, rf_tx_abort;
   logic [1:0] bresp, rresp, rf_state;
   logic [3:0] lk_tx_code;
   logic [7:0] lk_tx_len, rf_tx_len;
   int failures = 0, compares = 0, cycles = 0, n, starts = 0, reqs = 0;
   clt_session_ctrl #(.DEADLOCK_CYC(DL), .PATH_BASE_CYC(40), .PATH_BYTE_CYC(8),
      .SHDLC_CYC(100), .GUARD_CYC(60)) dut (.clock(clock), .srst(srst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .link_clk(link_clk), .link_rx_frame(link_rx_frame), .link_rx_bit(link_rx_bit),
      .lk_shdlc_pending(lk_shdlc_pending), .lk_tx_done(lk_tx_done), .lk_tx_req(lk_tx_req),
      .lk_tx_code(lk_tx_code), .lk_tx_len(lk_tx_len), .lk_tx_corrupt(lk_tx_corrupt),
      .lk_higher_cmd(lk_higher_cmd), .lk_deactivate(lk_deactivate), .rf_field(rf_field),
      .rf_selected(rf_selected), .rf_sel_from_halt(rf_sel_from_halt),
      .rf_blk_end(rf_blk_end), .rf_blk_len(rf_blk_len), .rf_req_cmd(rf_req_cmd),
      .rf_mod_edge(rf_mod_edge), .rf_state(rf_state), .rf_listen(rf_listen),
      .rf_tx_start(rf_tx_start), .rf_tx_len(rf_tx_len), .rf_tx_abort(rf_tx_abort));
   clt_card_model card (.clock(clock), .lk_tx_req(lk_tx_req), .lk_tx_done(lk_tx_done),
      .link_clk(link_clk), .link_rx_frame(link_rx_frame), .link_rx_bit(link_rx_bit));
   always #2 clock = ~clock;
   // Run should end near 8.6k cycles; anything far past that is a hang
   always @(posedge clock) begin
      cycles++;
      if (rf_tx_start === 1'h1) starts++;
      if (lk_tx_req === 1'h1) reqs++;
      if (cycles == 40000) begin
         failures++;
         test_done;
      end
   end
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      r = bresp;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clock);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      d = rdata;
      r = rresp;
   endtask
   // A field drop before selection starts a fresh session
   task automatic rf_blk(input logic sel, input logic fh, input logic [7:0] len);
      @(posedge clock);
      rf_field <= ~sel;
      @(posedge clock);
      rf_field <= 1'h1;
      rf_selected <= sel;
      rf_sel_from_halt <= fh;
      @(posedge clock);
      rf_selected <= 1'h0;
      repeat (2) @(posedge clock);
      rf_blk_end <= 1'h1;
      rf_blk_len <= len;
      @(posedge clock);
      rf_blk_end <= 1'h0;
   endtask
   task automatic link_req(input logic [3:0] code, input logic [7:0] len, input logic cor);
      for (n = 0; n < 50 && lk_tx_req !== 1'h1; n++) @(posedge clock);
      chk("lk_tx_req", 32'h1, {31'h0, lk_tx_req});
      chk("lk_tx_code", {28'h0, code}, {28'h0, lk_tx_code});
      chk("lk_tx_len", {24'h0, len}, {24'h0, lk_tx_len});
      chk("lk_tx_corrupt", {31'h0, cor}, {31'h0, lk_tx_corrupt});
      @(posedge clock);
      chk("rf_listen", 32'h0, {31'h0, rf_listen});
      for (n = 0; n < 100 && lk_tx_done !== 1'h1; n++) @(posedge clock);
   endtask
   task automatic ev_check(input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axr(REG_EVENTS, d, r);
      chk("events", exp, d);
      axw(REG_EVENTS, 32'hff, r);
   endtask
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axr(REG_CTRL, d, r);
      chk("ctrl_reset", 32'h0, d);
      axr(8'h0c, d, r);
      chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axw(REG_CTRL, 32'h1, r);
      chk("ctrl_wr_resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axr(REG_CTRL, d, r);
      chk("ctrl_rd", 32'h1, d);
      wstrb <= 4'h0;
      axw(REG_CTRL, 32'h0, r);
      wstrb <= 4'hf;
      axr(REG_CTRL, d, r);
      chk("ctrl_strb", 32'h1, d);
      $display("test regs done");
   endtask
   task automatic t_open;
      rf_blk(1'h1, 1'h0, 8'h02);
      link_req(CODE_NOTICE, 8'h02, 1'h0);
      card.send_frame(CODE_DATA, 2, 1'h1);
      repeat (8) @(posedge clock);
      chk("rf_tx_start_bad", 32'h0, starts);
      card.send_frame(CODE_DATA, 2, 1'h0);
      for (n = 0; n < 50 && rf_tx_start !== 1'h1; n++) @(posedge clock);
      chk("rf_tx_start", 32'h1, {31'h0, rf_tx_start});
      chk("rf_tx_len", 32'h2, {24'h0, rf_tx_len});
      rf_mod_edge <= 1'h1;
      @(posedge clock);
      rf_mod_edge <= 1'h0;
      ev_check(32'h22);
      $display("test open done");
   endtask
   task automatic t_timeout;
      lk_shdlc_pending <= 1'h1;
      rf_blk(1'h0, 1'h0, 8'h28);
      n = reqs;
      repeat (20) @(posedge clock);
      chk("lk_tx_req_held", n, reqs);
      lk_shdlc_pending <= 1'h0;
      link_req(CODE_DATA, 8'h1e, 1'h1);
      for (n = 0; n < DL + 50 && lk_higher_cmd !== 1'h1; n++)
         @(posedge clock);
      chk("rf_tx_start", 32'h1, starts);
      chk("lk_higher_cmd", 32'h1, {31'h0, lk_higher_cmd});
      chk("lk_deactivate", 32'h0, {31'h0, lk_deactivate});
      chk("timeout_not_early", 32'h1, {31'h0, n >= DL});
      chk("rf_state", {30'h0, RF_IDLE}, {30'h0, rf_state});
      $display("test timeout done");
   endtask
   task automatic t_goto(input logic fh, input logic [3:0] code, input logic [1:0] exp);
      rf_blk(1'h1, fh, 8'h02);
      link_req(CODE_NOTICE, 8'h02, 1'h0);
      card.send_frame(code, 0, 1'h0);
      for (n = 0; n < 100 && rf_state !== exp; n++) @(posedge clock);
      chk("rf_state", {30'h0, exp}, {30'h0, rf_state});
      $display("test goto done");
   endtask
   initial begin
      repeat (2) @(posedge clock);
      srst <= 1'h0;
      repeat (3) @(posedge clock);
      t_regs;
      t_open;
      t_timeout;
      rf_req_cmd <= 1'h1;
      t_goto(1'h0, CODE_HALT, RF_HALT);
      rf_req_cmd <= 1'h0;
      ev_check(32'h49);
      t_goto(1'h1, CODE_INIT, RF_HALT);
      t_goto(1'h0, CODE_INIT, RF_IDLE);
      test_done;
   end
endmodule
`default_nettype wire
